// file: hdl/sadc_defs.vh
/*
 * Constants for the SAR converter control and window detector: register
 * addresses, field positions, reset values, start source codes and timing counts.
 * Assumes inclusion by bare name from hdl/ design files; definitions only.
 */
`ifndef SADC_DEFS_VH
`define SADC_DEFS_VH

// ----------------------------------------------------------------------
// Register addresses (8-bit special function register space)
// ----------------------------------------------------------------------
`define SADC_ADDR_RES_HI    8'hBF
`define SADC_ADDR_LT_HI     8'hC7
`define SADC_ADDR_CFG       8'hBC
`define SADC_ADDR_CTL       8'hE8
`define SADC_ADDR_RES_LO    8'hBE
`define SADC_ADDR_GT_HI     8'hC5
`define SADC_ADDR_GT_LO     8'hC4
`define SADC_ADDR_LT_LO     8'hC6

// ----------------------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------------------
`define SADC_CTL_EN         7
`define SADC_CTL_TM         6
`define SADC_CTL_DONE       5
`define SADC_CTL_BUSY       4
`define SADC_CTL_CM_HI      3
`define SADC_CTL_CM_LO      2
`define SADC_CTL_WIN        1
`define SADC_CTL_LJST       0

// ----------------------------------------------------------------------
// Configuration register fields
// ----------------------------------------------------------------------
`define SADC_CFG_DIV_HI     7
`define SADC_CFG_DIV_LO     3
`define SADC_CFG_GAIN_HI    2
`define SADC_CFG_GAIN_LO    0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SADC_RST_CTL        8'h00
`define SADC_RST_CFG        8'hF8
`define SADC_RST_LIM        8'h00
`define SADC_RST_GT_HI      8'hFF
`define SADC_RST_GT_LO      8'hFF

// ----------------------------------------------------------------------
// Start sources
// ----------------------------------------------------------------------
`define SADC_CM_SW          2'h0
`define SADC_CM_T3          2'h1
`define SADC_CM_EXT         2'h2
`define SADC_CM_T2          2'h3

// ----------------------------------------------------------------------
// Timing in SAR clocks
// ----------------------------------------------------------------------
`define SADC_TRACK_SAR      3
`define SADC_CONV_SAR       16

`endif

// file: hdl/sadc_sar_tick.v
/*
 * SAR clock divider: pulses once every (divider + 1) system clocks.
 * Assumes the divider value is stable or that a glitch-free restart on
 * change is acceptable; counter restarts when run is low.
 */
`timescale 1ns/1ps

module sadc_sar_tick #(
    parameter DIV_W = 5
) (
    clk_sys,
    reset,
    run,
    divider,
    tick
);
    input  wire             clk_sys;
    input  wire             reset;
    input  wire             run;
    input  wire [DIV_W-1:0] divider;
    output reg              tick;

    reg [DIV_W-1:0] count_r;

    // ------------------------------------------------------------------
    // Divide by divider + 1
    // ------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (reset || !run) begin
            count_r <= {DIV_W{1'b0}};
            tick    <= 1'b0;
        end else if (count_r >= divider) begin
            count_r <= {DIV_W{1'b0}};
            tick    <= 1'b1;
        end else begin
            count_r <= count_r + 1'b1;
            tick    <= 1'b0;
        end
    end
endmodule // sadc_sar_tick

// file: hdl/sadc_control.v
/*
 * Control for a 10-bit SAR converter: start selection, track-and-hold
 * sequencing, result formatting and window detection, reached through
 * an 8-bit register port with address, write and read strobes.
 * Assumes all inputs synchronous to clk_sys; the analog core returns a
 * 10-bit code on adc_code once sar_done-time is reached (sampled at end).
 */
// What this block does
// - SAR clock is system clock divided by five-bit divider field plus one
// - Three-bit gain field maps to gain 1,2,4,8,16 or reduced gain
// - Enable bit set allows conversions; clear keeps converter shut down
// - Conversion phase lasts sixteen SAR clock periods at least
// - Right-justified result puts top two bits in high byte bits 1:0
// - Right-justified upper high bits sign-extend if differential, else zero
// - Left-justified result: top eight in high, low two in bits 7:6
// - Single-ended codes unsigned; differential codes two's complement
// - Every new result is compared with both limits automatically
// - Each limit word is kept as separate high and low byte registers
// - Limit ordering selects inside-window or outside-window detection
// - Window match sets control bit 1
// - Two-bit start field picks software, timer three, pin edge, timer two
// - Busy reads one during conversion; its fall at a completed conversion sets done flag
// - With tracking mode clear, input tracks whenever idle
// - Low-power mode with pin start tracks while pin low, converts on rise
`timescale 1ns/1ps

`include "sadc_defs.vh"

module sadc_control #(
    parameter RES_W = 10
) (
    clk_sys,
    reset,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    timer2_overflow,
    timer3_overflow,
    external_convert_start,
    differential_mode,
    adc_code,
    track_enable,
    convert_active,
    converter_powered,
    pga_gain_code,
    conversion_done_irq,
    window_match_irq
);
    input  wire             clk_sys;
    input  wire             reset;
    input  wire [7:0]       reg_addr;
    input  wire [7:0]       reg_wdata;
    input  wire             reg_wr;
    input  wire             reg_rd;
    output reg  [7:0]       reg_rdata;
    input  wire             timer2_overflow;
    input  wire             timer3_overflow;
    input  wire             external_convert_start;
    input  wire             differential_mode;
    input  wire [RES_W-1:0] adc_code;
    output reg              track_enable;
    output reg              convert_active;
    output reg              converter_powered;
    output reg  [2:0]       pga_gain_code;
    output reg              conversion_done_irq;
    output reg              window_match_irq;

    // State codes of the sequencer
    localparam ST_IDLE  = 2'h0;
    localparam ST_TRACK = 2'h1;
    localparam ST_CONV  = 2'h2;

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    reg [7:0]  cfg_r;
    reg        en_r;
    reg        tm_r;
    reg        done_r;
    reg        busy_r;
    reg [1:0]  cm_r;
    reg        win_r;
    reg        ljst_r;
    reg        diff_r;
    reg [7:0]  res_hi_r;
    reg [7:0]  res_lo_r;
    reg [7:0]  gt_hi_r;
    reg [7:0]  gt_lo_r;
    reg [7:0]  lt_hi_r;
    reg [7:0]  lt_lo_r;
    reg [1:0]  state_r;
    reg [4:0]  sar_cnt_r;
    reg        ext_d_r;

    wire       sar_tick;
    wire       ext_rise;
    wire       ctl_wr;
    wire       sw_start;
    wire       start_evt;

    // ------------------------------------------------------------------
    // SAR clock divider
    // ------------------------------------------------------------------
    // Divider idles between conversions: whole periods per phase
    sadc_sar_tick #(
        .DIV_W   (5)
    ) u_tick (
        .clk_sys (clk_sys),
        .reset   (reset),
        .run     (en_r && state_r != ST_IDLE),
        .divider (cfg_r[`SADC_CFG_DIV_HI:`SADC_CFG_DIV_LO]),
        .tick    (sar_tick)
    );

    // ------------------------------------------------------------------
    // Start event selection
    // ------------------------------------------------------------------
    // Pin edge detect; pin is already synchronous per assumption
    always @(posedge clk_sys) begin
        if (reset)
            ext_d_r <= 1'b0;
        else
            ext_d_r <= external_convert_start;
    end

    assign ext_rise  = external_convert_start & ~ext_d_r;
    assign ctl_wr    = reg_wr && (reg_addr == `SADC_ADDR_CTL);
    assign sw_start  = ctl_wr && reg_wdata[`SADC_CTL_BUSY]
                       && (cm_r == `SADC_CM_SW);
    // Mux of the four triggers
    assign start_evt = (cm_r == `SADC_CM_SW)  ? sw_start :
                       (cm_r == `SADC_CM_T3)  ? timer3_overflow :
                       (cm_r == `SADC_CM_EXT) ? ext_rise :
                                                timer2_overflow;

    // ------------------------------------------------------------------
    // Result formatting
    // ------------------------------------------------------------------
    // Code from the core: offset-free two's complement when differential
    reg  [15:0] word_fmt;
    reg  [15:0] gt_word;
    reg  [15:0] lt_word;
    reg         above_gt;
    reg         below_lt;
    reg         win_hit;

    always @* begin
        if (ljst_r)
            word_fmt = {adc_code, 6'h00};
        else if (differential_mode)
            word_fmt = {{6{adc_code[RES_W-1]}}, adc_code};
        else
            word_fmt = {6'h00, adc_code};
    end

    // ------------------------------------------------------------------
    // Window comparison on the formatted word
    // ------------------------------------------------------------------
    // Limits share the data format, so one compare covers all four cases
    always @* begin
        gt_word = {gt_hi_r, gt_lo_r};
        lt_word = {lt_hi_r, lt_lo_r};
        if (differential_mode) begin
            above_gt = $signed(word_fmt) > $signed(gt_word);
            below_lt = $signed(word_fmt) < $signed(lt_word);
        end else begin
            above_gt = word_fmt > gt_word;
            below_lt = word_fmt < lt_word;
        end
        // Ordered limits pick inside or outside detection
        if (differential_mode ? ($signed(lt_word) > $signed(gt_word))
                              : (lt_word > gt_word))
            win_hit = above_gt && below_lt;
        else
            win_hit = above_gt || below_lt;
    end

    // ------------------------------------------------------------------
    // Sequencer and control flags
    // ------------------------------------------------------------------
    // Set events win over software clears in the same cycle
    always @(posedge clk_sys) begin
        if (reset) begin
            en_r      <= 1'b0;
            tm_r      <= 1'b0;
            done_r    <= 1'b0;
            busy_r    <= 1'b0;
            cm_r      <= `SADC_CM_SW;
            win_r     <= 1'b0;
            ljst_r    <= 1'b0;
            diff_r    <= 1'b0;
            state_r   <= ST_IDLE;
            sar_cnt_r <= 5'h00;
            res_hi_r  <= 8'h00;
            res_lo_r  <= 8'h00;
        end else begin
            if (ctl_wr) begin
                en_r   <= reg_wdata[`SADC_CTL_EN];
                tm_r   <= reg_wdata[`SADC_CTL_TM];
                cm_r   <= reg_wdata[`SADC_CTL_CM_HI:`SADC_CTL_CM_LO];
                ljst_r <= reg_wdata[`SADC_CTL_LJST];
                done_r <= reg_wdata[`SADC_CTL_DONE];
                win_r  <= reg_wdata[`SADC_CTL_WIN];
            end

            if (reg_wr && reg_addr == `SADC_ADDR_RES_HI)
                res_hi_r <= reg_wdata;
            if (reg_wr && reg_addr == `SADC_ADDR_RES_LO)
                res_lo_r <= reg_wdata;

            case (state_r)
                ST_IDLE: begin
                    if (en_r && start_evt) begin
                        busy_r    <= 1'b1;
                        sar_cnt_r <= 5'h00;
                        if (tm_r && cm_r != `SADC_CM_EXT)
                            state_r <= ST_TRACK;
                        else
                            state_r <= ST_CONV;
                    end
                end
                ST_TRACK: begin
                    if (sar_tick) begin
                        if (sar_cnt_r == `SADC_TRACK_SAR - 1) begin
                            sar_cnt_r <= 5'h00;
                            state_r   <= ST_CONV;
                        end else begin
                            sar_cnt_r <= sar_cnt_r + 5'h01;
                        end
                    end
                end
                ST_CONV: begin
                    if (sar_tick) begin
                        if (sar_cnt_r == `SADC_CONV_SAR - 1) begin
                            busy_r   <= 1'b0;
                            done_r   <= 1'b1;
                            res_hi_r <= word_fmt[15:8];
                            res_lo_r <= word_fmt[7:0];
                            diff_r   <= differential_mode;
                            if (win_hit)
                                win_r <= 1'b1;
                            state_r  <= ST_IDLE;
                        end else begin
                            sar_cnt_r <= sar_cnt_r + 5'h01;
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase

            // Disabling mid-conversion abandons it without a result
            if (!en_r && state_r != ST_IDLE) begin
                state_r <= ST_IDLE;
                busy_r  <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Configuration, limit registers and read port
    // ------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (reset) begin
            cfg_r   <= `SADC_RST_CFG;
            gt_hi_r <= `SADC_RST_GT_HI;
            gt_lo_r <= `SADC_RST_GT_LO;
            lt_hi_r <= `SADC_RST_LIM;
            lt_lo_r <= `SADC_RST_LIM;
        end else if (reg_wr) begin
            case (reg_addr)
                `SADC_ADDR_CFG:   cfg_r   <= reg_wdata;
                `SADC_ADDR_GT_HI: gt_hi_r <= reg_wdata;
                `SADC_ADDR_GT_LO: gt_lo_r <= reg_wdata;
                `SADC_ADDR_LT_HI: lt_hi_r <= reg_wdata;
                `SADC_ADDR_LT_LO: lt_lo_r <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Registered read data; unmapped addresses return zero
    always @(posedge clk_sys) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `SADC_ADDR_CTL:    reg_rdata <= {en_r, tm_r, done_r, busy_r,
                                                 cm_r, win_r, ljst_r};
                `SADC_ADDR_CFG:    reg_rdata <= cfg_r;
                `SADC_ADDR_RES_HI: reg_rdata <= res_hi_r;
                `SADC_ADDR_RES_LO: reg_rdata <= res_lo_r;
                `SADC_ADDR_GT_HI:  reg_rdata <= gt_hi_r;
                `SADC_ADDR_GT_LO:  reg_rdata <= gt_lo_r;
                `SADC_ADDR_LT_HI:  reg_rdata <= lt_hi_r;
                `SADC_ADDR_LT_LO:  reg_rdata <= lt_lo_r;
                default:           reg_rdata <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Analog-facing and interrupt outputs, all registered
    // ------------------------------------------------------------------
    // Gain code 10x folds to 100 so the core sees one code per gain
    always @(posedge clk_sys) begin
        if (reset) begin
            track_enable        <= 1'b0;
            convert_active      <= 1'b0;
            converter_powered   <= 1'b0;
            pga_gain_code       <= 3'h0;
            conversion_done_irq <= 1'b0;
            window_match_irq    <= 1'b0;
        end else begin
            converter_powered <= en_r;
            convert_active    <= en_r && state_r == ST_CONV;
            if (!en_r)
                track_enable <= 1'b0;
            else if (state_r == ST_TRACK)
                track_enable <= 1'b1;
            else if (state_r == ST_CONV)
                track_enable <= 1'b0;
            else if (!tm_r)
                track_enable <= 1'b1;
            else if (cm_r == `SADC_CM_EXT)
                track_enable <= ~external_convert_start;
            else
                track_enable <= 1'b0;
            pga_gain_code <= cfg_r[`SADC_CFG_GAIN_HI] ?
                             {cfg_r[2:1], 1'b0} :
                             cfg_r[2:0];
            conversion_done_irq <= done_r;
            window_match_irq    <= win_r;
        end
    end
endmodule // sadc_control

// file: verif/sadc_control_checker.sv
/* Concurrent checks on the ports of sadc_control, bound to every instance.
   Assumes one-cycle register strobes and that
   sadc_defs.vh is on the include path. */
`timescale 1ns/1ps
`include "sadc_defs.vh"
module sadc_control_checker #(
    parameter RES_W = 10
) (
    input logic             clk_sys,
    input logic             reset,
    input logic [7:0]       reg_addr,
    input logic [7:0]       reg_wdata,
    input logic             reg_wr,
    input logic             reg_rd,
    input logic [7:0]       reg_rdata,
    input logic             timer2_overflow,
    input logic             timer3_overflow,
    input logic             external_convert_start,
    input logic             differential_mode,
    input logic [RES_W-1:0] adc_code,
    input logic             track_enable,
    input logic             convert_active,
    input logic             converter_powered,
    input logic [2:0]       pga_gain_code,
    input logic             conversion_done_irq,
    input logic             window_match_irq
);
    // ------------------------------------------------------------
    // Shadows of written fields and phase counters
    // ------------------------------------------------------------
    logic [4:0] div_r;
    logic       tm_r;
    logic [1:0] cm_r;
    logic [7:0] lim_r [0:3];
    logic [7:0] exp_r;
    logic [9:0] cnv_cnt_r;
    logic [9:0] trk_cnt_r;
    wire wr_ctl = reg_wr && reg_addr == `SADC_ADDR_CTL;
    wire wr_cfg = reg_wr && reg_addr == `SADC_ADDR_CFG;
    wire in_lim = reg_addr[7:2] == 6'h31;
    wire wclr   = wr_ctl && !reg_wdata[1];
    wire [8:0] sar = {4'h0, div_r} + 9'h001;
    wire mapped = in_lim || wr_ctl || reg_addr == `SADC_ADDR_CTL
        || reg_addr == `SADC_ADDR_CFG || reg_addr == `SADC_ADDR_RES_HI
        || reg_addr == `SADC_ADDR_RES_LO;

    // Fields follow the writes so no internal probe is needed
    always @(posedge clk_sys) begin
        if (reset) begin
            div_r    <= 5'h1F;
            tm_r     <= 1'b0;
            cm_r     <= 2'h0;
            lim_r[0] <= `SADC_RST_GT_LO;
            lim_r[1] <= `SADC_RST_GT_HI;
            lim_r[2] <= `SADC_RST_LIM;
            lim_r[3] <= `SADC_RST_LIM;
        end else begin
            if (wr_cfg) div_r <= reg_wdata[7:3];
            if (wr_ctl) tm_r <= reg_wdata[6];
            if (wr_ctl) cm_r <= reg_wdata[3:2];
            if (reg_wr && in_lim) lim_r[reg_addr[1:0]] <= reg_wdata;
        end
    end

    // Saturating track count, so a long idle track never wraps into range
    always @(posedge clk_sys) begin
        exp_r     <= lim_r[reg_addr[1:0]];
        cnv_cnt_r <= convert_active ? cnv_cnt_r + 10'h001 : 10'h000;
        if (!track_enable) trk_cnt_r <= 10'h000;
        else if (trk_cnt_r != 10'h3FF) trk_cnt_r <= trk_cnt_r + 10'h001;
    end

    function automatic logic [2:0] gmap(input logic [2:0] g);
        gmap = g[2] ? {g[2:1], 1'b0} : g;
    endfunction

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence conv_end;
        $fell(convert_active) && converter_powered;
    endsequence
    sequence idle6;
        (converter_powered && !tm_r && !convert_active) [*6];
    endsequence

    a_conv_length: assert property (conv_end |-> cnv_cnt_r >= 16*sar-1
        && cnv_cnt_r <= 17*sar+2) else $error("conversion phase length off");
    a_done_after: assert property (conv_end |-> ##[0:2] conversion_done_irq)
        else $error("done flag missing after conversion");
    a_done_cause: assert property ($rose(conversion_done_irq) |->
        $past(convert_active) || $past(convert_active, 2)
        || $past(convert_active, 3)) else $error("done without conversion");
    // Only short tracks count: mode changes end long idle tracking
    a_track_phase: assert property ($fell(track_enable) && tm_r
        && cm_r != `SADC_CM_EXT && trk_cnt_r < 14 |->
        trk_cnt_r >= 3*sar-1 && trk_cnt_r <= 3*sar+1)
        else $error("low power track length off");
    a_power_ctl: assert property (wr_ctl |-> ##2
        converter_powered == $past(reg_wdata[7], 2))
        else $error("powered does not follow enable");
    a_gain_cfg: assert property (wr_cfg |-> ##2
        pga_gain_code == gmap($past(reg_wdata[2:0], 2)))
        else $error("gain code mismatch");
    a_rd_unmapped: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rd_limit: assert property (reg_rd && in_lim |=> reg_rdata == exp_r)
        else $error("limit readback mismatch");
    a_track_conv: assert property (!(track_enable && convert_active))
        else $error("tracking during conversion");
    a_off_idle: assert property (!converter_powered ##1 !converter_powered
        |-> !convert_active) else $error("conversion while shut down");
    a_idle_track: assert property (idle6 |-> track_enable)
        else $error("no tracking while idle");
    a_win_hold: assert property (window_match_irq && !wclr && !$past(wclr)
        |=> window_match_irq) else $error("window flag dropped");
endmodule // sadc_control_checker

bind sadc_control sadc_control_checker #(.RES_W(RES_W)) u_chk (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .timer2_overflow(timer2_overflow),
    .timer3_overflow(timer3_overflow),
    .external_convert_start(external_convert_start),
    .differential_mode(differential_mode), .adc_code(adc_code),
    .track_enable(track_enable), .convert_active(convert_active),
    .converter_powered(converter_powered), .pga_gain_code(pga_gain_code),
    .conversion_done_irq(conversion_done_irq),
    .window_match_irq(window_match_irq));

// file: verif/sar_adc_control_window_detect_tb.sv
/* Self-checking bench for sadc_control with a behavioural model.
   Assumes the checker is bound and sadc_defs.vh is on the path. */
`timescale 1ns/1ps
`include "sadc_defs.vh"
module sar_adc_control_window_detect_tb;
    logic       clk_sys = 1'b0;
    logic       reset   = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic       t2 = 1'b0;
    logic       t3 = 1'b0;
    logic       ext = 1'b0;
    logic       diff = 1'b0;
    logic [9:0] code = 10'h000;
    wire  [7:0] reg_rdata;
    wire  [2:0] gain;
    wire        trk, cnv, pwr, done_irq, win_irq;
    int         miscompares = 0;
    int         n_compared = 0;
    int         seed = 50;

    sadc_control u_sadc_control (
        .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .timer2_overflow(t2),
        .timer3_overflow(t3), .external_convert_start(ext),
        .differential_mode(diff), .adc_code(code), .track_enable(trk),
        .convert_active(cnv), .converter_powered(pwr),
        .pga_gain_code(gain), .conversion_done_irq(done_irq),
        .window_match_irq(win_irq));

    always #10 clk_sys = ~clk_sys;

    // ------------------------------------------------------------
    // Bus tasks, compare and model
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Strobe drops at the next edge, so the next call starts one later
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    function automatic logic [15:0] fmt(logic [9:0] c, logic d, logic lj);
        fmt = lj ? {c, 6'h00} : d ? {{6{c[9]}}, c} : {6'h00, c};
    endfunction

    // Inside window when less-than is above greater-than, else outside
    function automatic logic hit(logic [15:0] x, gt, lt, logic d);
        int xv, g, l;
        if (d) begin
            xv = $signed(x);
            g  = $signed(gt);
            l  = $signed(lt);
        end else begin
            xv = x;
            g  = gt;
            l  = lt;
        end
        hit = (l > g) ? (xv > g && xv < l) : (xv > g || xv < l);
    endfunction

    task automatic complete_run;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // About 1000 cycles are expected; twenty times that means a hang
    initial begin
        #(20 * 20000);
        miscompares++;
        complete_run();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0]  ra [7];
        logic [7:0]  rv [7];
        logic [15:0] gt, lt, w;
        logic [9:0]  c;
        logic [7:0]  b, h, ctl;
        logic [1:0]  cm;
        logic        d, lj, tm, wm;
        ra = '{`SADC_ADDR_CTL, `SADC_ADDR_CFG, `SADC_ADDR_GT_HI,
               `SADC_ADDR_GT_LO, `SADC_ADDR_LT_HI, `SADC_ADDR_LT_LO, 8'h00};
        rv = '{`SADC_RST_CTL, `SADC_RST_CFG, `SADC_RST_GT_HI,
               `SADC_RST_GT_LO, `SADC_RST_LIM, `SADC_RST_LIM, 8'h00};
        wm = 1'b0;
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        foreach (ra[i]) begin
            rd(ra[i], b);
            chk("reset read", rv[i], b);
        end
        for (int g = 0; g < 8; g++) begin
            wr(`SADC_ADDR_CFG, g[7:0]);
            repeat (2) @(posedge clk_sys);
            #1 chk("gain", g[2] ? {g[2:1], 1'b0} : g[2:0], gain);
        end
        // Busy without enable must leave the converter asleep
        wr(`SADC_ADDR_CTL, 8'h10);
        repeat (40) @(posedge clk_sys);
        #1 chk("shut down", 16'h0000, {pwr, cnv, done_irq});
        for (int i = 0; i < 16; i++) begin
            cm = i[1:0];
            b  = $random(seed);
            tm = b[1];
            lj = b[2];
            d  = b[3];
            c  = $random(seed);
            w  = fmt(c, d, lj);
            gt = w + 16'($random(seed) % 4);
            lt = w + 16'($random(seed) % 4);
            if (!i[0]) wm = 1'b0;
            ctl = {1'b1, tm, 2'b00, cm, wm, lj};
            @(posedge clk_sys);
            code <= c;
            diff <= d;
            if (cm == `SADC_CM_EXT) ext <= 1'b0;
            wr(`SADC_ADDR_CFG, {4'h0, b[0], 3'h0});
            wr(`SADC_ADDR_GT_HI, gt[15:8]);
            wr(`SADC_ADDR_GT_LO, gt[7:0]);
            wr(`SADC_ADDR_LT_HI, lt[15:8]);
            wr(`SADC_ADDR_LT_LO, lt[7:0]);
            wr(`SADC_ADDR_CTL, ctl);
            if (cm != `SADC_CM_SW) wr(`SADC_ADDR_CTL, ctl | 8'h10);
            repeat (10) @(posedge clk_sys);
            #1 chk("busy ignored", 16'h0000, cnv);
            chk("idle track", tm ? cm == `SADC_CM_EXT : 1'b1, trk);
            @(posedge clk_sys);
            case (cm)
                `SADC_CM_SW: wr(`SADC_ADDR_CTL, ctl | 8'h10);
                `SADC_CM_T3: t3 <= 1'b1;
                `SADC_CM_EXT: ext <= 1'b1;
                default: t2 <= 1'b1;
            endcase
            @(posedge clk_sys);
            t3 <= 1'b0;
            t2 <= 1'b0;
            for (int k = 0; k < 2000 && done_irq !== 1'b1; k++)
                @(negedge clk_sys);
            chk("done irq", 16'h0001, done_irq);
            wm = wm | hit(w, gt, lt, d);
            rd(`SADC_ADDR_RES_HI, h);
            rd(`SADC_ADDR_RES_LO, b);
            chk("result high", w[15:8], h);
            chk("result low", w[7:0], b);
            chk("result word", w, {h, b});
            rd(`SADC_ADDR_CTL, b);
            chk("busy done", 16'h0001, {b[4], b[5]});
            chk("window flag", wm, b[1]);
            chk("window irq", wm, win_irq);
        end
        complete_run();
    end
endmodule // sar_adc_control_window_detect_tb
